/* File: src/ssp_pkg.sv */
package ssp_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG_STAT = 8'h04;
	localparam logic [7:0] ADDR_DATA_BUF = 8'h08;

	// ----------------------------------------------------------------
	// Field positions in serial_mode_control
	// ----------------------------------------------------------------
	localparam int MC_MODE_LSB = 5;
	localparam int MC_UART_BIT = 4;
	localparam int MC_DEB_LSB = 2;
	localparam int MC_EN_BIT = 1;
	localparam int MC_INC_BIT = 0;

	// ----------------------------------------------------------------
	// Field positions in spi_config_status
	// ----------------------------------------------------------------
	localparam int CS_SPARE_LSB = 6;
	localparam int CS_CKPOLB_BIT = 5;
	localparam int CS_CKEG_BIT = 4;
	localparam int CS_ORDER_BIT = 3;
	localparam int CS_SELECT_PIN_ENABLE_BIT = 2;
	localparam int CS_WRITE_COLLISION_FLAG_BIT = 1;
	localparam int CS_TRF_BIT = 0;

	// ----------------------------------------------------------------
	// Mode codes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_M_DIV4 = 3'h0;
	localparam logic [2:0] MODE_M_DIV16 = 3'h1;
	localparam logic [2:0] MODE_M_DIV64 = 3'h2;
	localparam logic [2:0] MODE_M_SUB = 3'h3;
	localparam logic [2:0] MODE_M_TMR = 3'h4;
	localparam logic [2:0] MODE_SLAVE = 3'h5;
	localparam logic [2:0] MODE_I2C = 3'h6;
	localparam logic [2:0] MODE_RST = 3'h7;

	// ----------------------------------------------------------------
	// Timing: SCK half period in system clocks minus one, then edge and bit counts
	// ----------------------------------------------------------------
	localparam logic [4:0] DIV4_LIM = 5'h01;
	localparam logic [4:0] DIV16_LIM = 5'h07;
	localparam logic [4:0] DIV64_LIM = 5'h1F;
	localparam logic [3:0] LAST_EDGE = 4'hF;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sck;
		logic sdi;
		logic selN;
		logic subClk;
	} ssp_pin_in_t;

	typedef struct packed {
		logic sckOut;
		logic sckOe;
		logic sdoOut;
		logic sdoOe;
		logic selNOut;
		logic selNOe;
	} ssp_pin_out_t;

	typedef struct packed {
		logic [2:0] mode;
		logic uartSel;
		logic [1:0] debounce;
		logic enable;
		logic incomplete;
		logic [1:0] spare;
		logic ckpolb;
		logic ckeg;
		logic bitOrder;
		logic select_pin_enable;
		logic write_collision_flag;
		logic transfer_done_flag;
		logic [7:0] dataBuf;
		logic [7:0] txSh;
		logic [7:0] rxSh;
		logic busy;
		logic [3:0] edgeCnt;
		logic [3:0] capCnt;
		logic capPend;
		logic [4:0] divCnt;
		logic sckLvl;
		logic sckPrev;
		logic subPrev;
		logic pready;
		logic pslverr;
		logic [7:0] prdata;
		ssp_pin_out_t pins;
	} ssp_state_t;

endpackage

/* File: src/ssp_sync.sv */
`timescale 1ns/1ps
module ssp_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] stage1_ff;
	logic [W-1:0] stage2_ff;

	initial
	begin
		if (W < 1)
			$error("ssp_sync width must be at least 1");
	end

	// ----------------------------------------------------------------
	// Two flop synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			stage1_ff <= RST_VAL;
			stage2_ff <= RST_VAL;
		end
		else
		begin
			stage1_ff <= d;
			stage2_ff <= stage1_ff;
		end
	end

	assign q = stage2_ff;
endmodule

/* File: src/ssp_top.sv */
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
// How it works
// R01: UART bit plus mode field pick function
// R02: Full duplex, master or slave operation
// R03: Only master starts transfers, drives clock
// R04: Four lines: SDI, SDO, SCK, select
// R05: Select enable set uses pin, else float
// R06: One select pin, one slave only
// R07: Extra slaves need general I/O selects
// R08: Software picks LSB or MSB first
// R09: Software picks rising or falling capture
// R10: One eight-bit data register for all
// R11: Load before transfer, read after it
// R12: Config and data live only in SPI
// R13: Control split over two registers
// R14: Pin state follows role and enables
// R15: Pins work only when shared-selected
// R16: Data register meaningless until written or filled
// R17: Mode codes: masters, slave, I2C
// R18: Master data write starts a transfer
// R19: Done flag sets, software clears it
// R20: Busy write ignored, collision flag set
// R21: Exactly eight bits through shift registers
// R22: Slave shifts only while selected
module ssp_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pin sharing and master clock sources
	input wire logic pinFuncSel,
	input wire logic timerMatch,
	// Link pins
	input ssp_pkg::ssp_pin_in_t pinIn,
	output ssp_pkg::ssp_pin_out_t pinOut
);
	import ssp_pkg::*;

	ssp_state_t st;
	ssp_state_t nxt;
	ssp_pin_in_t pinS;
	logic spiSel;
	logic masterAct;
	logic slaveAct;
	logic selected;
	logic apbReq;
	logic apbWr;
	logic addrHit;
	logic [7:0] rdVal;
	logic tick;
	logic capRise;
	logic [7:0] rxNext;
	logic [7:0] txNext;
	logic dataWr;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	ssp_sync #(
		.W(4),
		.RST_VAL(4'h2)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d(pinIn),
		.q(pinS)
	);

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	assign spiSel = !st.uartSel && (st.mode <= MODE_SLAVE); // [R01] [R12] [R17]
	assign masterAct = st.enable && spiSel && pinFuncSel && (st.mode <= MODE_M_TMR); // [R15]
	assign slaveAct = st.enable && spiSel && pinFuncSel && (st.mode == MODE_SLAVE); // [R15]
	assign selected = !st.select_pin_enable || !pinS.selN; // [R22]
	assign capRise = !(st.ckpolb ^ st.ckeg); // [R09]
	assign rxNext = st.bitOrder ? {st.rxSh[6:0], pinS.sdi} : {pinS.sdi, st.rxSh[7:1]}; // [R08]
	assign txNext = st.bitOrder ? {st.txSh[6:0], 1'b0} : {1'b0, st.txSh[7:1]}; // [R08]

	// ----------------------------------------------------------------
	// Master clock tick select
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (st.mode)
			MODE_M_DIV4: tick = (st.divCnt >= DIV4_LIM);
			MODE_M_DIV16: tick = (st.divCnt >= DIV16_LIM);
			MODE_M_DIV64: tick = (st.divCnt >= DIV64_LIM);
			MODE_M_SUB: tick = (pinS.subClk != st.subPrev);
			MODE_M_TMR: tick = timerMatch;
			default: tick = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign apbReq = psel && penable && !st.pready;
	assign apbWr = psel && penable && st.pready && pwrite && !st.pslverr;
	assign addrHit = (paddr == ADDR_MODE_CTRL) || (paddr == ADDR_CFG_STAT)
		|| (paddr == ADDR_DATA_BUF);
	assign dataWr = apbWr && (paddr == ADDR_DATA_BUF) && spiSel; // [R12]

	always_comb
	begin
		rdVal = 8'h00;
		if (paddr == ADDR_MODE_CTRL)
			rdVal = {st.mode, st.uartSel, st.debounce, st.enable, st.incomplete}; // [R13]
		else if (paddr == ADDR_CFG_STAT && spiSel) // [R12]
			rdVal = {st.spare, st.ckpolb, st.ckeg, st.bitOrder, st.select_pin_enable, st.write_collision_flag, st.transfer_done_flag};
		else if (paddr == ADDR_DATA_BUF && spiSel) // [R12]
			rdVal = st.dataBuf; // [R10] [R11]
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt = st;
		nxt.pready = apbReq;
		if (apbReq)
		begin
			nxt.pslverr = !addrHit;
			nxt.prdata = rdVal;
		end
		else
			nxt.pslverr = 1'b0;
		nxt.sckPrev = pinS.sck;
		nxt.subPrev = pinS.subClk;

		// Register writes
		if (apbWr && paddr == ADDR_MODE_CTRL)
		begin
			nxt.mode = pwdata[MC_MODE_LSB +: 3]; // [R01] [R13]
			nxt.uartSel = pwdata[MC_UART_BIT];
			nxt.debounce = pwdata[MC_DEB_LSB +: 2];
			nxt.enable = pwdata[MC_EN_BIT];
			nxt.incomplete = pwdata[MC_INC_BIT];
		end
		if (apbWr && paddr == ADDR_CFG_STAT && spiSel) // [R12]
		begin
			nxt.spare = pwdata[CS_SPARE_LSB +: 2];
			nxt.ckpolb = pwdata[CS_CKPOLB_BIT];
			nxt.ckeg = pwdata[CS_CKEG_BIT];
			nxt.bitOrder = pwdata[CS_ORDER_BIT]; // [R13]
			nxt.select_pin_enable = pwdata[CS_SELECT_PIN_ENABLE_BIT];
			nxt.write_collision_flag = pwdata[CS_WRITE_COLLISION_FLAG_BIT];
			nxt.transfer_done_flag = pwdata[CS_TRF_BIT]; // [R19]
		end
		if (dataWr)
		begin
			if (st.busy)
				nxt.write_collision_flag = 1'b1; // [R20]
			else
			begin
				nxt.dataBuf = pwdata[7:0]; // [R10] [R16]
				if (masterAct)
				begin
					nxt.txSh = pwdata[7:0]; // [R18] [R21]
					nxt.busy = 1'b1; // [R03] [R18]
					nxt.edgeCnt = 4'h0;
					nxt.capCnt = 4'h0;
					nxt.divCnt = 5'h00;
				end
			end
		end

		// Master engine
		if (masterAct)
		begin
			if (!st.busy)
				nxt.sckLvl = !st.ckpolb;
			else
			begin
				// Capture one clock after the edge: the input needs two flops first
				if (st.capPend)
				begin
					nxt.rxSh = rxNext; // [R02] [R09]
					nxt.capPend = 1'b0;
				end
				if (st.capCnt == BITS_PER_BYTE && st.edgeCnt == 4'h0)
				begin
					if (!st.capPend)
					begin
						nxt.busy = 1'b0; // [R21]
						nxt.transfer_done_flag = 1'b1; // [R19]
						nxt.dataBuf = st.rxSh; // [R11]
					end
				end
				else
				begin
					nxt.divCnt = tick ? 5'h00 : st.divCnt + 5'h01;
					if (tick)
					begin
						nxt.sckLvl = !st.sckLvl; // [R03]
						nxt.edgeCnt = st.edgeCnt + 4'h1;
						if (!st.sckLvl == capRise)
						begin
							nxt.capPend = 1'b1; // [R09]
							nxt.capCnt = st.capCnt + 4'h1;
						end
						else if (st.capCnt != 4'h0)
							nxt.txSh = txNext; // [R08]
					end
				end
			end
		end
		else if (slaveAct)
		begin
			if (!st.busy)
				nxt.txSh = nxt.dataBuf; // [R10]
			if (st.select_pin_enable && pinS.selN && st.busy)
			begin
				nxt.busy = 1'b0;
				nxt.incomplete = 1'b1;
				nxt.transfer_done_flag = 1'b1; // [R19]
				nxt.capCnt = 4'h0;
			end
			else if (!selected)
				nxt.capCnt = 4'h0; // [R22]
			else if (pinS.sck != st.sckPrev)
			begin
				if (pinS.sck == capRise)
				begin
					nxt.rxSh = rxNext; // [R02] [R22]
					nxt.capCnt = st.capCnt + 4'h1;
					nxt.busy = 1'b1;
					if (st.capCnt == BITS_PER_BYTE - 4'h1)
					begin
						nxt.busy = 1'b0; // [R21]
						nxt.capCnt = 4'h0;
						nxt.transfer_done_flag = 1'b1; // [R19]
						nxt.dataBuf = rxNext; // [R11]
					end
				end
				else if (st.capCnt != 4'h0)
					nxt.txSh = txNext; // [R08]
			end
		end
		else
		begin
			nxt.busy = 1'b0;
			nxt.capCnt = 4'h0;
			nxt.capPend = 1'b0;
			nxt.sckLvl = !st.ckpolb;
		end

		// Pin drive
		nxt.pins.sckOut = nxt.sckLvl;
		nxt.pins.sckOe = masterAct; // [R03] [R14]
		nxt.pins.sdoOut = nxt.bitOrder ? nxt.txSh[7] : nxt.txSh[0]; // [R04] [R08]
		nxt.pins.sdoOe = masterAct || (slaveAct && selected); // [R14]
		nxt.pins.selNOut = !nxt.busy; // [R06]
		nxt.pins.selNOe = masterAct && st.select_pin_enable; // [R05] [R14]
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.mode <= MODE_RST;
			st.sckLvl <= 1'b1;
			st.pins.selNOut <= 1'b1;
			st.pins.sckOut <= 1'b1;
		end
		else
			st <= nxt;
	end

	assign prdata = {24'h000000, st.prdata};
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign pinOut = st.pins;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_write_collision_flag;
		dataWr && st.busy |=> st.write_collision_flag && $stable(st.dataBuf);
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) // [R20]
		else $error("collision write not flagged or not ignored");

	property p_trf_hold;
		st.transfer_done_flag && !(apbWr && paddr == ADDR_CFG_STAT) |=> st.transfer_done_flag;
	endproperty
	a_trf_hold: assert property (p_trf_hold) // [R19]
		else $error("done flag dropped without software clear");

	property p_start;
		dataWr && !st.busy && masterAct |=> st.busy && st.txSh == $past(pwdata[7:0]);
	endproperty
	a_start: assert property (p_start) // [R18]
		else $error("master write did not start transfer");

	property p_slave_clk;
		!masterAct |=> !st.pins.sckOe;
	endproperty
	a_slave_clk: assert property (p_slave_clk) // [R03]
		else $error("clock driven while not master");

	property p_sel_float;
		!st.select_pin_enable |=> !st.pins.selNOe;
	endproperty
	a_sel_float: assert property (p_sel_float) // [R05]
		else $error("select pin driven while disabled");

	property p_len;
		$rose(st.busy) && masterAct && st.mode == MODE_M_DIV4 |-> st.busy [*8];
	endproperty
	a_len: assert property (p_len) // [R21]
		else $error("master transfer ended too early");

	property p_desel;
		slaveAct && st.select_pin_enable && pinS.selN && !st.busy |=> !st.busy;
	endproperty
	a_desel: assert property (p_desel) // [R22]
		else $error("slave shifted while deselected");

	property p_nospi_read;
		apbReq && !pwrite && paddr == ADDR_DATA_BUF && !spiSel |=> st.prdata == 8'h00;
	endproperty
	a_nospi_read: assert property (p_nospi_read) // [R12]
		else $error("data register visible outside SPI mode");

	property p_uart_pins;
		st.uartSel |=> !st.pins.sckOe && !st.pins.sdoOe && !st.pins.selNOe;
	endproperty
	a_uart_pins: assert property (p_uart_pins) // [R01]
		else $error("SPI pins driven in UART mode");
endmodule

/* File: tb/ssp_peer.sv */
`timescale 1ns/1ps
module ssp_peer (
	// Setup
	input wire logic ckpolb,
	input wire logic ckeg,
	input wire logic peerMaster,
	input wire logic go,
	input wire logic [7:0] txByte,
	// Link lines
	input wire logic sckLine,
	input wire logic selLine,
	input wire logic sdoLine,
	output logic sckDrv,
	output logic selDrv,
	output logic sdiDrv,
	output logic [7:0] rxByte
);
	logic [7:0] sh;
	int cnt;

	initial
	begin
		sckDrv = 1'b1;
		selDrv = 1'b1;
		sdiDrv = 1'b0;
		rxByte = 8'h00;
		sh = 8'h00;
		cnt = 0;
	end

	// ----
	// Shifter, MSB first
	// ----
	always @(negedge selLine)
	begin
		cnt = 0;
		sh = txByte;
		sdiDrv = sh[7];
	end

	// Released line shows the inverse of its last value
	always @(posedge selLine) sdiDrv = ~sdiDrv;

	always @(sckLine)
		if (!selLine)
		begin
			if (sckLine == ~(ckpolb ^ ckeg))
			begin
				rxByte = {rxByte[6:0], sdoLine};
				cnt++;
			end
			else if (cnt > 0)
			begin
				sh = sh << 1;
				sdiDrv = sh[7];
			end
		end

	// ----
	// Master role: clock only inside frames
	// ----
	always @(posedge go)
		if (peerMaster)
		begin
			sckDrv = ~ckpolb;
			#40 selDrv = 1'b0;
			repeat (16) #32 sckDrv = ~sckDrv;
			#40 selDrv = 1'b1;
		end
endmodule

/* File: tb/shared_serial_spi_port_test.sv */
`timescale 1ns/1ps
module shared_serial_spi_port_test;
	import ssp_pkg::*;
	logic clk_sys, rst_n, psel, penable, pwrite, pinFuncSel, timerMatch, subClk;
	logic pready, pslverr, er, pCkp, pCke, pMst, go, sckDrv, selDrv, sdiDrv;
	logic sckLine, selLine;
	logic [7:0] tick = 8'h00;
	logic [7:0] paddr, cfg, tx, pTx, pRx;
	logic [31:0] pwdata, prdata, rd;
	ssp_pin_in_t pinIn;
	ssp_pin_out_t pinOut;
	int nFail, checkCount;

	assign sckLine = pinOut.sckOe ? pinOut.sckOut : sckDrv;
	assign selLine = pinOut.selNOe ? pinOut.selNOut : selDrv;
	assign pinIn = {sckLine, sdiDrv, selLine, subClk};

	ssp_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pinFuncSel(pinFuncSel), .timerMatch(timerMatch),
		.pinIn(pinIn), .pinOut(pinOut));

	ssp_peer peer (.ckpolb(pCkp), .ckeg(pCke), .peerMaster(pMst), .go(go), .txByte(pTx),
		.sckLine(sckLine), .selLine(selLine), .sdoLine(pinOut.sdoOut), .sckDrv(sckDrv),
		.selDrv(selDrv), .sdiDrv(sdiDrv), .rxByte(pRx));

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Slow clock sources for modes 011 and 100
	always @(posedge clk_sys)
	begin
		tick <= tick + 8'h01;
		timerMatch <= (tick[1:0] == 2'h3);
		subClk <= tick[2];
	end

	// ----
	// Tasks
	// ----
	task automatic close_out();
		if (nFail == 0 && checkCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			nFail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
		begin
			nFail++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_trf();
		int k;
		for (k = 0; k < 400; k++)
		begin
			apb(1'b0, ADDR_CFG_STAT, 32'h00000000);
			if (rd[0] === 1'b1)
				break;
		end
		if (k == 400)
		begin
			nFail++;
			close_out();
		end
	endtask

	function automatic logic [7:0] rev(input logic [7:0] b);
		for (int k = 0; k < 8; k++)
			rev[k] = b[7 - k];
	endfunction

	// ----
	// Sequence
	// ----
	initial
	begin
		{rst_n, psel, penable, pwrite, pinFuncSel} = 5'h00;
		{pCkp, pCke, pMst, go} = 4'h0;
		{paddr, pTx} = 16'h0000;
		pwdata = 32'h00000000;
		nFail = 0;
		checkCount = 0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(1'b0, ADDR_MODE_CTRL, 32'h00000000);
		chk(rd, 32'h000000E0);
		apb(1'b0, ADDR_CFG_STAT, 32'h00000000);
		chk(rd, 32'h00000000);
		apb(1'b0, 8'h0C, 32'h00000000);
		chk({31'h0, er}, 32'h00000001);
		apb(1'b1, ADDR_MODE_CTRL, 32'h00000012);
		apb(1'b1, ADDR_CFG_STAT, 32'h0000000C);
		apb(1'b0, ADDR_CFG_STAT, 32'h00000000);
		chk(rd, 32'h00000000);
		chk({29'h0, pinOut.sckOe, pinOut.sdoOe, pinOut.selNOe}, 32'h00000000);
		pinFuncSel <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			cfg = {2'h0, i[1], i[0], i[2], 3'h4};
			tx = 8'h1B + 8'(i * 37);
			pTx = 8'hC6 ^ 8'(i);
			pCkp <= i[1];
			pCke <= i[0];
			apb(1'b1, ADDR_MODE_CTRL, {24'h0, 3'(i % 5), 5'h02});
			apb(1'b1, ADDR_CFG_STAT, {24'h0, cfg});
			apb(1'b0, ADDR_MODE_CTRL, 32'h00000000);
			chk(rd, {24'h0, 3'(i % 5), 5'h02});
			apb(1'b1, ADDR_DATA_BUF, {24'h0, tx});
			if (i == 0)
				apb(1'b1, ADDR_DATA_BUF, 32'h000000FF);
			wait_trf();
			chk(rd, {24'h0, cfg | 8'h01 | ((i == 0) ? 8'h02 : 8'h00)});
			apb(1'b0, ADDR_DATA_BUF, 32'h00000000);
			chk(rd, {24'h0, cfg[3] ? pTx : rev(pTx)});
			chk({24'h0, pRx}, {24'h0, cfg[3] ? tx : rev(tx)});
			apb(1'b1, ADDR_CFG_STAT, {24'h0, cfg});
			apb(1'b0, ADDR_CFG_STAT, 32'h00000000);
			chk(rd, {24'h0, cfg});
		end
		apb(1'b1, ADDR_CFG_STAT, 32'h00000008);
		repeat (2) @(negedge clk_sys);
		chk({31'h0, pinOut.selNOe}, 32'h00000000);
		apb(1'b1, ADDR_MODE_CTRL, 32'h000000A2);
		apb(1'b1, ADDR_CFG_STAT, 32'h0000000C);
		pCkp <= 1'b0;
		pCke <= 1'b0;
		pMst <= 1'b1;
		pTx = 8'h69;
		apb(1'b1, ADDR_DATA_BUF, 32'h00000096);
		repeat (2) @(negedge clk_sys);
		chk({30'h0, pinOut.sckOe, pinOut.selNOe}, 32'h00000000);
		@(posedge clk_sys);
		go <= 1'b1;
		wait_trf();
		go <= 1'b0;
		chk(rd, 32'h0000000D);
		apb(1'b0, ADDR_DATA_BUF, 32'h00000000);
		chk(rd, 32'h00000069);
		chk({24'h0, pRx}, 32'h00000096);
		close_out();
	end
endmodule
